// ### bench/bcp_core_sva.sv
// Port-level checks of the commutation core
`timescale 1ns/10ps
module bcp_core_sva (
  input wire clock,
  input wire rst_n,
  input wire pready,
  input wire pslverr,
  input wire hall_phase_u,
  input wire hall_phase_v,
  input wire hall_phase_w,
  input wire limitTrip,
  input wire undervoltageTrip,
  input wire overtempTrip,
  input wire [2:0] topEnable,
  input wire [2:0] bottomEnable,
  input wire speed_pulse_three,
  input wire speed_pulse_one,
  input wire hall_supply_out,
  input wire irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire [2:0] hallIn = {hall_phase_u, hall_phase_v, hall_phase_w};
  wire maj = (hall_phase_u & hall_phase_v) | (hallIn[0] & (hall_phase_u | hall_phase_v));
  wire allOff = (topEnable == 3'h0) && (bottomEnable == 3'h0);
  a_apb_zero_wait: assert property (pready && !pslverr) else $error("apb wait or error");
  a_no_shoot_through: assert property ((topEnable & bottomEnable) == 3'h0)
    else $error("top and bottom on together");
  a_fg_three_majority: assert property ($stable(hallIn)[*8] |->
    speed_pulse_three == maj) else $error("three-pulse not majority");
  a_fg_one_follow: assert property ($stable(hallIn)[*8] |->
    speed_pulse_one == hall_phase_u) else $error("one-pulse not phase u");
  a_alloff_gates: assert property (!hall_supply_out[*3] |-> allOff)
    else $error("arm on in all-off band");
  a_limit_bottom: assert property (limitTrip[*8] |-> bottomEnable == 3'h0)
    else $error("bottom on during limit");
  a_undervolt_off: assert property (undervoltageTrip[*8] |-> allOff)
    else $error("arm on during undervoltage");
  a_overtemp_off: assert property (overtempTrip[*8] |-> allOff)
    else $error("arm on during overtemp");
  cover property (limitTrip && topEnable != 3'h0);
  cover property ($fell(hall_supply_out));
  cover property (irq);
endmodule // bcp_core_sva

bind bcp_core bcp_core_sva u_sva (.clock, .rst_n, .pready, .pslverr, .hall_phase_u, .hall_phase_v,
  .hall_phase_w, .limitTrip, .undervoltageTrip, .overtempTrip, .topEnable, .bottomEnable,
  .speed_pulse_three, .speed_pulse_one, .hall_supply_out, .irq);

// ### bench/bcp_hall_model.sv
// Hall sensor model: three levels, all low when unpowered
`timescale 1ns/10ps
module bcp_hall_model (
  input wire hall_supply_out,
  input wire [2:0] angleCode,
  output wire hall_phase_u,
  output wire hall_phase_v,
  output wire hall_phase_w
);
  // Unpowered elements leave every comparator low
  assign {hall_phase_u, hall_phase_v, hall_phase_w} =
    hall_supply_out ? angleCode : 3'h0;
endmodule // bcp_hall_model

// ### bench/tb.sv
// Self-checking bench for the commutation core
`timescale 1ns/10ps
`include "bcp_regs.vh"
module tb;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] angleCode = 3'h5;
  logic limitTrip = 1'b0, overcurrentTrip = 1'b0;
  logic [1:0] tripIn = 2'h0, relIn = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr, hu, hv, hw, irq, fg3, fg1, hallSup, pwmClk;
  wire [2:0] topEnable, bottomEnable;
  int error_cnt = 0, total_checks = 0, n, m, k;
  always #12.5 clock = ~clock;
  bcp_core u_dut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .hall_phase_u(hu), .hall_phase_v(hv), .hall_phase_w(hw), .limitTrip,
    .overcurrentTrip, .undervoltageTrip(tripIn[0]), .undervoltageRelease(relIn[0]),
    .overtempTrip(tripIn[1]), .overtempRelease(relIn[1]), .topEnable, .bottomEnable,
    .speed_pulse_three(fg3), .speed_pulse_one(fg1), .hall_supply_out(hallSup),
    .pwm_clock_out(pwmClk), .irq);
  bcp_hall_model u_hall (.hall_supply_out(hallSup), .angleCode, .hall_phase_u(hu),
    .hall_phase_v(hv), .hall_phase_w(hw));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Gates and speed outputs: pm bit1 keeps tops, bit0 keeps bottoms
  function automatic logic [7:0] want(input logic [2:0] h, input logic [1:0] pm);
    logic [5:0] g;
    case (h)
      3'h5: g = 6'h14;
      3'h4: g = 6'h0c;
      3'h6: g = 6'h0a;
      3'h2: g = 6'h22;
      3'h3: g = 6'h21;
      3'h1: g = 6'h11;
      default: g = 6'h00;
    endcase
    want = {g[5:3] & {3{pm[1]}}, g[2:0] & {3{pm[0]}},
            (h[2] & h[1]) | (h[0] & (h[2] | h[1])), h[2]};
  endfunction
  task automatic waitg(input logic [7:0] e, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clock);
      if ({topEnable, bottomEnable, fg3, fg1} === e) break;
    end
    chk({24'h0, topEnable, bottomEnable, fg3, fg1}, {24'h0, e});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge clock);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chk({25'h0, topEnable, bottomEnable, irq}, 32'h0);
    rdc(`BCP_ADDR_CTRL, 32'h0);
    rdc(12'h1fc, 32'h0);
    wr_speed: apb(1'b1, `BCP_ADDR_SPEED, 32'hff);
    for (n = 0; n < 8; n++) begin
      angleCode <= n[2:0];
      waitg(want(n[2:0], 2'h3), 64);
    end
    chk({31'h0, hallSup}, 32'h1);
    angleCode <= 3'h5;
    apb(1'b1, `BCP_ADDR_SPEED, 32'h80);
    waitg(want(3'h5, 2'h3), 2000);
    m = 0;
    k = 0;
    repeat (3840) begin
      @(posedge clock);
      m += bottomEnable[2] + (topEnable == 3'h2 ? 0 : 1000);
      k += pwmClk;
    end
    chk({31'h0, m > 1500 && m < 2300}, 32'h1);
    chk({31'h0, k > 1900 && k < 1940}, 32'h1);
    apb(1'b1, `BCP_ADDR_SPEED, 32'h30);
    waitg(want(3'h5, 2'h2), 64);
    apb(1'b1, `BCP_ADDR_SPEED, 32'h10);
    waitg(want(3'h0, 2'h0), 64);
    chk({31'h0, hallSup}, 32'h0);
    apb(1'b1, `BCP_ADDR_SPEED, 32'hff);
    waitg(want(3'h5, 2'h3), 64);
    limitTrip <= 1'b1;
    waitg(want(3'h5, 2'h2), 64);
    rdc(`BCP_ADDR_IRQ_STAT, 32'h10);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `BCP_ADDR_IRQ_EN, 32'h1f);
    rdc(`BCP_ADDR_IRQ_EN, 32'h1f);
    chk({31'h0, irq}, 32'h1);
    limitTrip <= 1'b0;
    waitg(want(3'h5, 2'h3), 4000);
    apb(1'b1, `BCP_ADDR_IRQ_CLR, 32'h10);
    rdc(`BCP_ADDR_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (n = 0; n < 2; n++) begin
      tripIn[n] <= 1'b1;
      waitg(want(3'h5, 2'h0), 64);
      tripIn[n] <= 1'b0;
      repeat (12) @(posedge clock);
      waitg(want(3'h5, 2'h0), 1);
      rdc(`BCP_ADDR_IRQ_STAT, 32'h2 << n);
      relIn[n] <= 1'b1;
      waitg(want(3'h5, 2'h3), 64);
      relIn[n] <= 1'b0;
      apb(1'b1, `BCP_ADDR_IRQ_CLR, 32'h1f);
    end
    apb(1'b1, `BCP_ADDR_CTRL, 32'h2);
    overcurrentTrip <= 1'b1;
    waitg(want(3'h5, 2'h0), 64);
    overcurrentTrip <= 1'b0;
    for (n = 0; n < 45000; n++) begin
      @(posedge clock);
      if ({topEnable, bottomEnable} !== 6'h0) break;
    end
    chk({31'h0, n > 39950 && n < 40020}, 32'h1);
    waitg(want(3'h5, 2'h3), 4);
    tally_and_finish;
  end
endmodule // tb

// ### pkg/bcp_regs.vh
// Register map, field positions and timing constants of the commutation core
`ifndef BCP_REGS_VH
`define BCP_REGS_VH
`define BCP_CLK_HZ 40000000
`define BCP_ADDR_CTRL 12'h000
`define BCP_ADDR_SPEED 12'h004
`define BCP_ADDR_STATUS 12'h008
`define BCP_ADDR_IRQ_STAT 12'h00c
`define BCP_ADDR_IRQ_EN 12'h010
`define BCP_ADDR_IRQ_CLR 12'h014
`define BCP_ADDR_GATES 12'h018
`define BCP_CTRL_RESET 2'h0
`define BCP_CTRL_LOCKEN 0
`define BCP_CTRL_OCEN 1
`define BCP_SPEED_RESET 8'h00
`define BCP_SAW_LOW 8'h40
`define BCP_SAW_HIGH 8'hc0
`define BCP_ALLOFF_LVL 8'h25
`define BCP_LOCKSUP_LVL 8'h43
`define BCP_PWM_HZ 20000
`define BCP_PWM_DIV (`BCP_CLK_HZ / `BCP_PWM_HZ / 128)
`define BCP_OCREC_US 1000
`define BCP_OCREC_CYC (`BCP_CLK_HZ / 1000000 * `BCP_OCREC_US)
`define BCP_LOCKDET_US 2000
`define BCP_LOCKDET_CYC (`BCP_CLK_HZ / 1000000 * `BCP_LOCKDET_US)
`define BCP_LOCKREL_US 12000
`define BCP_LOCKREL_CYC (`BCP_CLK_HZ / 1000000 * `BCP_LOCKREL_US)
`define BCP_EV_OC 0
`define BCP_EV_UV 1
`define BCP_EV_OT 2
`define BCP_EV_LOCK 3
`define BCP_EV_LIMIT 4
`endif

// ### rtl/bcp_core.v
// Commutation, PWM and protection core with APB register access
// Function
// - Hall code selects six arm enables
// - Three-pulse is majority, one-pulse follows U
// - PWM chops bottom arms only
// - Current limit kills bottoms until PWM tick
// - Over-current kills all, timed recovery
// - Undervoltage kills all until release
// - Stop band holds bottoms off
// - All-off band holds every arm off
// - Unchanged three-pulse for time declares lock
// - Lock holds arms off for release time
// - Lock detect suppressed low command, UV, OT
// - Over-temperature kills all until release
// - Hall supply on above all-off level
// - Hall supply off forces Hall low
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "bcp_regs.vh"
module bcp_core (
  input wire clock,
  input wire rst_n,
  input wire [31:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire hall_phase_u,
  input wire hall_phase_v,
  input wire hall_phase_w,
  input wire limitTrip,
  input wire overcurrentTrip,
  input wire undervoltageTrip,
  input wire undervoltageRelease,
  input wire overtempTrip,
  input wire overtempRelease,
  output reg [2:0] topEnable,
  output reg [2:0] bottomEnable,
  output reg speed_pulse_three,
  output reg speed_pulse_one,
  output reg hall_supply_out,
  output reg pwm_clock_out,
  output wire irq
);
  reg [1:0] ctrl_r;
  reg [7:0] speed_command_r;
  reg [4:0] irqStat_r;
  reg [4:0] irqEn_r;
  reg [6:0] ramp_r;
  reg [15:0] div_r;
  reg pwmTick;
  reg limitLatch_r;
  reg uvActive_r;
  reg otActive_r;
  reg lockActive_r;
  reg ocPrev_r;
  reg fgPrev_r;
  reg [4:0] events;
  reg [2:0] topDec;
  reg [2:0] botDec;
  wire hu;
  wire hv;
  wire hw;
  wire ocSync;
  wire limSync;
  wire uvTrip;
  wire uvRel;
  wire otTrip;
  wire otRel;
  wire ocBusy;
  wire lockDetBusy;
  wire lockRelBusy;
  wire [2:0] hallGated;
  wire fg3;
  wire pwmOn;
  wire allOffBand;
  wire stopBand;
  wire lockSuppress;
  wire ocStart;
  wire lockStart;
  wire fgEdge;
  wire shutAll;
  wire shutBottom;
  wire wrEn;
  wire [6:0] speedCode;
  wire [7:0] speedOffset;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  bcp_sync uSyncHu (.clock(clock), .rst_n(rst_n), .din(hall_phase_u), .dout(hu));
  bcp_sync uSyncHv (.clock(clock), .rst_n(rst_n), .din(hall_phase_v), .dout(hv));
  bcp_sync uSyncHw (.clock(clock), .rst_n(rst_n), .din(hall_phase_w), .dout(hw));
  bcp_sync uSyncLim (.clock(clock), .rst_n(rst_n), .din(limitTrip), .dout(limSync));
  bcp_sync uSyncOc (.clock(clock), .rst_n(rst_n), .din(overcurrentTrip), .dout(ocSync));
  bcp_sync uSyncUvT (.clock(clock), .rst_n(rst_n), .din(undervoltageTrip), .dout(uvTrip));
  bcp_sync uSyncUvR (.clock(clock), .rst_n(rst_n), .din(undervoltageRelease), .dout(uvRel));
  bcp_sync uSyncOtT (.clock(clock), .rst_n(rst_n), .din(overtempTrip), .dout(otTrip));
  bcp_sync uSyncOtR (.clock(clock), .rst_n(rst_n), .din(overtempRelease), .dout(otRel));

  ////////////////////////////////////////////////////////////////////////
  // Command bands and Hall supply
  assign allOffBand = (speed_command_r < `BCP_ALLOFF_LVL);
  assign stopBand = !allOffBand && (speed_command_r < `BCP_SAW_LOW);
  assign lockSuppress = (speed_command_r <= `BCP_LOCKSUP_LVL) ||
                        uvActive_r || otActive_r;

  // Unpowered Hall elements read low
  assign hallGated = hall_supply_out ? {hu, hv, hw} : 3'h0;
  assign fg3 = (hallGated[2] & hallGated[1]) | (hallGated[2] & hallGated[0]) |
               (hallGated[1] & hallGated[0]);

  ////////////////////////////////////////////////////////////////////////
  // PWM ramp and clock tick
  // Command between the ramp floor and ceiling maps one to one onto the 128-step ramp
  assign speedOffset = speed_command_r - `BCP_SAW_LOW;
  assign speedCode = (speed_command_r >= `BCP_SAW_HIGH) ? 7'h7f :
                     (speed_command_r < `BCP_SAW_LOW) ? 7'h00 :
                     speedOffset[6:0];
  assign pwmOn = (speed_command_r >= `BCP_SAW_HIGH) ||
                 ({1'b0, speedCode} > {1'b0, ramp_r});

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0;
      ramp_r <= 7'h0;
      pwmTick <= 1'b0;
      pwm_clock_out <= 1'b0;
    end else begin
      pwmTick <= 1'b0;
      if ({16'h0, div_r} >= (`BCP_PWM_DIV - 1)) begin
        div_r <= 16'h0;
        ramp_r <= ramp_r + 7'h1;
        pwmTick <= (ramp_r == 7'h7f);
      end else begin
        div_r <= div_r + 16'h1;
      end
      pwm_clock_out <= ramp_r[6];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protection state
  assign ocStart = ocSync && !ocPrev_r && ctrl_r[`BCP_CTRL_OCEN];
  bcp_timer uOcTimer (.clock(clock), .rst_n(rst_n), .load(ocStart || (ocSync && ocBusy)),
    .loadVal(`BCP_OCREC_CYC), .busy(ocBusy));

  assign fgEdge = (fg3 != fgPrev_r);
  assign lockStart = !lockDetBusy && !lockActive_r && !lockSuppress &&
                     ctrl_r[`BCP_CTRL_LOCKEN] && !fgEdge;
  bcp_timer uLockDet (.clock(clock), .rst_n(rst_n),
    .load(fgEdge || lockSuppress || lockActive_r || !ctrl_r[`BCP_CTRL_LOCKEN] ||
          (lockStart && !lockRelBusy)),
    .loadVal(`BCP_LOCKDET_CYC), .busy(lockDetBusy));
  bcp_timer uLockRel (.clock(clock), .rst_n(rst_n), .load(lockStart),
    .loadVal(`BCP_LOCKREL_CYC), .busy(lockRelBusy));

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ocPrev_r <= 1'b0;
      fgPrev_r <= 1'b0;
      limitLatch_r <= 1'b0;
      uvActive_r <= 1'b0;
      otActive_r <= 1'b0;
      lockActive_r <= 1'b0;
    end else begin
      ocPrev_r <= ocSync;
      fgPrev_r <= fg3;
      if (limSync) begin
        limitLatch_r <= 1'b1;
      end else if (pwmTick) begin
        limitLatch_r <= 1'b0;
      end
      if (uvTrip) begin
        uvActive_r <= 1'b1;
      end else if (uvRel) begin
        uvActive_r <= 1'b0;
      end
      if (otTrip) begin
        otActive_r <= 1'b1;
      end else if (otRel) begin
        otActive_r <= 1'b0;
      end
      if (lockStart) begin
        lockActive_r <= 1'b1;
      end else if (lockActive_r && !lockRelBusy) begin
        lockActive_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hall decode and gate enables, bit 2 is phase U
  always @* begin
    case (hallGated)
      3'b101: begin
        topDec = 3'b010;
        botDec = 3'b100;
      end
      3'b100: begin
        topDec = 3'b001;
        botDec = 3'b100;
      end
      3'b110: begin
        topDec = 3'b001;
        botDec = 3'b010;
      end
      3'b010: begin
        topDec = 3'b100;
        botDec = 3'b010;
      end
      3'b011: begin
        topDec = 3'b100;
        botDec = 3'b001;
      end
      3'b001: begin
        topDec = 3'b010;
        botDec = 3'b001;
      end
      default: begin
        topDec = 3'b000;
        botDec = 3'b000;
      end
    endcase
  end

  assign shutAll = ocBusy || ocSync || uvActive_r || otActive_r || lockActive_r ||
                   allOffBand;
  assign shutBottom = limitLatch_r || limSync || stopBand || !pwmOn;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      topEnable <= 3'h0;
      bottomEnable <= 3'h0;
      speed_pulse_three <= 1'b0;
      speed_pulse_one <= 1'b0;
      hall_supply_out <= 1'b0;
    end else begin
      topEnable <= shutAll ? 3'h0 : topDec;
      bottomEnable <= (shutAll || shutBottom) ? 3'h0 : botDec;
      speed_pulse_three <= fg3;
      speed_pulse_one <= hallGated[2];
      hall_supply_out <= (speed_command_r > `BCP_ALLOFF_LVL);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events
  always @* begin
    events = 5'h0;
    events[`BCP_EV_OC] = ocStart;
    events[`BCP_EV_UV] = uvTrip && !uvActive_r;
    events[`BCP_EV_OT] = otTrip && !otActive_r;
    events[`BCP_EV_LOCK] = lockStart;
    events[`BCP_EV_LIMIT] = limSync && !limitLatch_r;
  end
  assign irq = |(irqStat_r & irqEn_r);

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn = psel && penable && pwrite;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `BCP_CTRL_RESET;
      speed_command_r <= `BCP_SPEED_RESET;
      irqEn_r <= 5'h0;
      irqStat_r <= 5'h0;
    end else begin
      if (wrEn && pstrb[0] && paddr[11:0] == `BCP_ADDR_CTRL) begin
        ctrl_r <= pwdata[1:0];
      end
      if (wrEn && pstrb[0] && paddr[11:0] == `BCP_ADDR_SPEED) begin
        speed_command_r <= pwdata[7:0];
      end
      if (wrEn && pstrb[0] && paddr[11:0] == `BCP_ADDR_IRQ_EN) begin
        irqEn_r <= pwdata[4:0];
      end
      // Set wins over a simultaneous clear
      if (wrEn && pstrb[0] && paddr[11:0] == `BCP_ADDR_IRQ_CLR) begin
        irqStat_r <= (irqStat_r & ~pwdata[4:0]) | events;
      end else begin
        irqStat_r <= irqStat_r | events;
      end
    end
  end

  always @* begin
    case (paddr[11:0])
      `BCP_ADDR_CTRL: prdata = {30'h0, ctrl_r};
      `BCP_ADDR_SPEED: prdata = {24'h0, speed_command_r};
      `BCP_ADDR_STATUS: prdata = {24'h0, lockActive_r, otActive_r, uvActive_r,
                                  ocBusy, limitLatch_r, hallGated};
      `BCP_ADDR_IRQ_STAT: prdata = {27'h0, irqStat_r};
      `BCP_ADDR_IRQ_EN: prdata = {27'h0, irqEn_r};
      `BCP_ADDR_GATES: prdata = {26'h0, topEnable, bottomEnable};
      default: prdata = 32'h0;
    endcase
  end
endmodule // bcp_core

// ### rtl/bcp_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module bcp_sync (
  input wire clock,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // bcp_sync

// ### rtl/bcp_timer.v
// Down counter: load, count and busy flag
`timescale 1ns/10ps
module bcp_timer (
  input wire clock,
  input wire rst_n,
  input wire load,
  input wire [31:0] loadVal,
  output wire busy
);
  reg [31:0] cnt_r;

  assign busy = (cnt_r != 32'h0);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
    end else if (load) begin
      cnt_r <= loadVal;
    end else if (busy) begin
      cnt_r <= cnt_r - 32'h1;
    end
  end
endmodule // bcp_timer
